// ---- core/pso_pkg.sv ----
// ****************************************************************
// constants and carriers for the sensor output status block
// ****************************************************************
`default_nettype none
package pso_pkg;

  // register byte addresses
  localparam logic [7:0] PSO_ADDR_QUEUE_CTRL  = 8'h14;  // watermark field lives here
  localparam logic [7:0] PSO_ADDR_OFFSET_LOW  = 8'h18;  // offset correction low byte
  localparam logic [7:0] PSO_ADDR_OFFSET_HIGH = 8'h19;  // offset correction high byte
  localparam logic [7:0] PSO_ADDR_QUEUE_FILL  = 8'h26;  // queue_fill_status
  localparam logic [7:0] PSO_ADDR_FLAGS       = 8'h27;  // sample_flags
  localparam logic [7:0] PSO_ADDR_PRESS_LOW   = 8'h28;  // pressure_result_low
  localparam logic [7:0] PSO_ADDR_PRESS_MID   = 8'h29;  // pressure_result_mid
  localparam logic [7:0] PSO_ADDR_PRESS_HIGH  = 8'h2A;  // pressure_result_high
  localparam logic [7:0] PSO_ADDR_TEMP_LOW    = 8'h2B;  // temperature_result_low
  localparam logic [7:0] PSO_ADDR_TEMP_HIGH   = 8'h2C;  // temperature_result_high
  localparam logic [7:0] PSO_ADDR_FILTER_RES  = 8'h33;  // filter_reset_register

  // field positions
  localparam int PSO_BIT_QUEUE_THRESH = 7;  // queue_threshold_flag
  localparam int PSO_BIT_QUEUE_OVR    = 6;  // queue_overrun_flag
  localparam int PSO_BIT_TEMP_OVR     = 5;  // temperature overrun
  localparam int PSO_BIT_PRESS_OVR    = 4;  // pressure overrun
  localparam int PSO_BIT_TEMP_AVAIL   = 1;  // temperature_available
  localparam int PSO_BIT_PRESS_AVAIL  = 0;  // pressure_available

  // widths and sizes
  localparam int PSO_FILL_W       = 6;   // queue_fill_level width
  localparam int PSO_WTM_W        = 5;   // watermark_level width
  localparam int PSO_QUEUE_DEPTH  = 32;  // most unread samples
  localparam int PSO_PRESS_W      = 24;  // pressure result width
  localparam int PSO_TEMP_W       = 16;  // temperature result width
  localparam int PSO_OFFSET_W     = 16;  // offset correction width
  localparam int PSO_OFFSET_SHIFT = 8;   // offset scaled by 256

  // reset values
  localparam logic [PSO_WTM_W-1:0]    PSO_WTM_RESET    = 5'h00;
  localparam logic [PSO_OFFSET_W-1:0] PSO_OFFSET_RESET = 16'h0000;
  localparam logic [7:0]              PSO_BYTE_ZERO    = 8'h00;

  // register port request from the serial front end
  typedef struct packed {
    logic       rd;     // one-cycle read strobe
    logic       wr;     // one-cycle write strobe
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write byte
  } pso_reg_req_t;

  // pressure sample from the conversion core
  typedef struct packed {
    logic                   valid;  // one-cycle new result
    logic [PSO_PRESS_W-1:0] value;  // raw two's complement pressure
  } pso_press_sample_t;

  // temperature sample from the conversion core
  typedef struct packed {
    logic                  valid;  // one-cycle new result
    logic [PSO_TEMP_W-1:0] value;  // two's complement temperature
  } pso_temp_sample_t;

  // mode levels; all but the low-pass filter bypass the offset subtraction
  typedef struct packed {
    logic differential_enable;        // differential mode
    logic autozero_enable;            // autozero function
    logic reference_offset_function;  // reference offset function
    logic pressure_lowpass_filter;    // low-pass filter active
  } pso_modes_t;

endpackage

`default_nettype wire

// ---- core/pso_status_core.sv ----
// How it works
// - threshold flag high when fill reaches watermark
// - watermark from five-bit field at 14h
// - queue overrun only when full and overwritten
// - six-bit fill count, zero to 32
// - overwrite in full queue shows 1,1,100000
// - temperature overrun on unread result replaced
// - pressure overrun on unread result replaced
// - temperature available set on new result
// - pressure available set on new result
// - sample flags snapshot refreshed each data period
// - 24-bit pressure over bytes 28h to 2Ah
// - output is raw minus offset when modes off
// - offset scaled by 256 before subtraction
// - 16-bit temperature over bytes 2Bh, 2Ch
// - reading 33h resets active low-pass filter
`timescale 1ns/100ps
`default_nettype none

module pso_status_core
  import pso_pkg::*;
#(
  parameter int QUEUE_DEPTH = PSO_QUEUE_DEPTH  // most unread queue samples
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire pso_reg_req_t      reg_req,
  input  wire pso_press_sample_t press_sample,
  input  wire pso_temp_sample_t  temp_sample,
  input  wire logic              odr_tick,
  input  wire pso_modes_t        modes,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   filter_reset
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // depth must fit the six-bit fill count
  if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > (2 ** PSO_FILL_W) - 1) begin : g_bad_depth
    $error("queue depth does not fit fill count");
  end

  localparam logic [PSO_FILL_W-1:0] DEPTH_FILL = PSO_FILL_W'(QUEUE_DEPTH);  // full count
  localparam logic [PSO_FILL_W-1:0] FILL_ONE   = 6'h01;                     // count step
  localparam logic [PSO_FILL_W-1:0] FILL_ZERO  = 6'h00;                     // empty count

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [PSO_WTM_W-1:0]    watermark_level;     // threshold compare level
  logic [PSO_OFFSET_W-1:0] offset_correction;   // stored offset
  logic [PSO_PRESS_W-1:0]  pressure_result;     // corrected pressure
  logic [PSO_TEMP_W-1:0]   temperature_result;  // temperature
  logic [PSO_FILL_W-1:0]   queue_fill_level;    // unread samples
  logic                    queue_overrun_flag;  // overwrite seen while full
  logic                    press_avail_live;    // live pressure available
  logic                    temp_avail_live;     // live temperature available
  logic                    press_ovr_live;      // live pressure overrun
  logic                    temp_ovr_live;       // live temperature overrun
  logic [3:0]              flags_snap;          // refreshed status bits

  // ****************************************************************
  // decode
  // ****************************************************************
  logic rd_press_high;  // read of top pressure byte
  logic rd_temp_high;   // read of top temperature byte
  logic queue_push;     // new sample enters queue
  logic queue_pop;      // host takes a sample
  logic queue_full;     // queue holds depth
  logic queue_thresh;   // fill at or above watermark
  logic modes_off;      // no mode bypasses the offset

  assign rd_press_high = reg_req.rd && (reg_req.addr == PSO_ADDR_PRESS_HIGH);
  assign rd_temp_high  = reg_req.rd && (reg_req.addr == PSO_ADDR_TEMP_HIGH);
  assign queue_push    = press_sample.valid;
  assign queue_full    = (queue_fill_level == DEPTH_FILL);
  assign queue_pop     = rd_press_high && (queue_fill_level != FILL_ZERO);
  assign queue_thresh  = ({1'b0, watermark_level} <= queue_fill_level);
  assign modes_off     = !modes.differential_enable && !modes.autozero_enable
                         && !modes.reference_offset_function;

  // ****************************************************************
  // writable configuration
  // ****************************************************************
  // watermark field from the queue control register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      watermark_level <= PSO_WTM_RESET;
    end else if (reg_req.wr && reg_req.addr == PSO_ADDR_QUEUE_CTRL) begin
      watermark_level <= reg_req.wdata[PSO_WTM_W-1:0];
    end
  end

  // offset correction bytes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      offset_correction <= PSO_OFFSET_RESET;
    end else if (reg_req.wr && reg_req.addr == PSO_ADDR_OFFSET_LOW) begin
      offset_correction[7:0] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == PSO_ADDR_OFFSET_HIGH) begin
      offset_correction[15:8] <= reg_req.wdata;
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  // pressure latched on each new sample, corrected when modes are off
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pressure_result <= '0;
    end else if (press_sample.valid) begin
      if (modes_off) begin
        pressure_result <= press_sample.value
                           - {offset_correction, {PSO_OFFSET_SHIFT{1'b0}}};
      end else begin
        pressure_result <= press_sample.value;  // other modes correct upstream
      end
    end
  end

  // temperature latched on each new sample
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      temperature_result <= '0;
    end else if (temp_sample.valid) begin
      temperature_result <= temp_sample.value;
    end
  end

  // ****************************************************************
  // sample queue count
  // ****************************************************************
  // push and pop together keep the count; a push while full overwrites
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      queue_fill_level <= FILL_ZERO;
    end else if (queue_push && !queue_pop && !queue_full) begin
      queue_fill_level <= queue_fill_level + FILL_ONE;
    end else if (queue_pop && !queue_push) begin
      queue_fill_level <= queue_fill_level - FILL_ONE;
    end
  end

  // overrun held only while the queue stays full
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      queue_overrun_flag <= 1'b0;
    end else if (queue_push && queue_full && !queue_pop) begin
      queue_overrun_flag <= 1'b1;
    end else if (queue_pop && !queue_push) begin
      queue_overrun_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // data available and overrun flags
  // ****************************************************************
  // pressure flags: a new result wins over a clearing read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      press_avail_live <= 1'b0;
      press_ovr_live   <= 1'b0;
    end else if (press_sample.valid) begin
      press_avail_live <= 1'b1;
      if (press_avail_live) begin
        press_ovr_live <= 1'b1;
      end
    end else if (rd_press_high) begin
      press_avail_live <= 1'b0;
      press_ovr_live   <= 1'b0;
    end
  end

  // temperature flags: a new result wins over a clearing read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      temp_avail_live <= 1'b0;
      temp_ovr_live   <= 1'b0;
    end else if (temp_sample.valid) begin
      temp_avail_live <= 1'b1;
      if (temp_avail_live) begin
        temp_ovr_live <= 1'b1;
      end
    end else if (rd_temp_high) begin
      temp_avail_live <= 1'b0;
      temp_ovr_live   <= 1'b0;
    end
  end

  // snapshot taken once per data period
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_snap <= 4'h0;
    end else if (odr_tick) begin
      flags_snap <= {temp_ovr_live, press_ovr_live, temp_avail_live, press_avail_live};
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] next_rd_data;  // selected byte

  // address mux; unmapped addresses read zero
  always_comb begin
    next_rd_data = PSO_BYTE_ZERO;
    case (reg_req.addr)
      PSO_ADDR_QUEUE_CTRL:  next_rd_data[PSO_WTM_W-1:0] = watermark_level;  // upper bits zero
      PSO_ADDR_OFFSET_LOW:  next_rd_data = offset_correction[7:0];
      PSO_ADDR_OFFSET_HIGH: next_rd_data = offset_correction[15:8];
      PSO_ADDR_QUEUE_FILL: begin
        next_rd_data[PSO_FILL_W-1:0]      = queue_fill_level;
        next_rd_data[PSO_BIT_QUEUE_OVR]    = queue_overrun_flag;
        next_rd_data[PSO_BIT_QUEUE_THRESH] = queue_thresh;
      end
      PSO_ADDR_FLAGS: begin
        next_rd_data[PSO_BIT_TEMP_OVR]    = flags_snap[3];  // other bits zero
        next_rd_data[PSO_BIT_PRESS_OVR]   = flags_snap[2];
        next_rd_data[PSO_BIT_TEMP_AVAIL]  = flags_snap[1];
        next_rd_data[PSO_BIT_PRESS_AVAIL] = flags_snap[0];
      end
      PSO_ADDR_PRESS_LOW:   next_rd_data = pressure_result[7:0];
      PSO_ADDR_PRESS_MID:   next_rd_data = pressure_result[15:8];
      PSO_ADDR_PRESS_HIGH:  next_rd_data = pressure_result[23:16];
      PSO_ADDR_TEMP_LOW:    next_rd_data = temperature_result[7:0];
      PSO_ADDR_TEMP_HIGH:   next_rd_data = temperature_result[15:8];
      default:              next_rd_data = PSO_BYTE_ZERO;              // unmapped reads zero
    endcase
  end

  // registered read answer one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data  <= PSO_BYTE_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // filter reset pulse on a read of its register while the filter runs
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      filter_reset <= 1'b0;
    end else begin
      filter_reset <= reg_req.rd && (reg_req.addr == PSO_ADDR_FILTER_RES)
                      && modes.pressure_lowpass_filter;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_filter_read;
    reg_req.rd && reg_req.addr == PSO_ADDR_FILTER_RES && modes.pressure_lowpass_filter;
  endsequence

  sequence s_full_push;
    queue_push && queue_full && !queue_pop;
  endsequence

  sequence s_fill_read;
    reg_req.rd && reg_req.addr == PSO_ADDR_QUEUE_FILL;
  endsequence

  sequence s_flags_read;
    reg_req.rd && reg_req.addr == PSO_ADDR_FLAGS;
  endsequence

  a_thresh_compare: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_fill_read |=> rd_data[PSO_BIT_QUEUE_THRESH] == ($past(queue_fill_level) >= $past(watermark_level)))
    else $error("threshold flag disagrees with fill and watermark");

  a_wtm_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == PSO_ADDR_QUEUE_CTRL |=> watermark_level == $past(reg_req.wdata[PSO_WTM_W-1:0]))
    else $error("watermark not taken from control write");

  a_ovr_needs_full: assert property (@(posedge sys_clk) disable iff (!reset_n)
    queue_overrun_flag |-> queue_full)
    else $error("queue overrun shown while not full");

  a_fill_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    queue_fill_level <= DEPTH_FILL)
    else $error("fill level beyond depth");

  a_full_overwrite: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_full_push |=> queue_overrun_flag && queue_thresh && queue_fill_level == DEPTH_FILL)
    else $error("overwrite status not 1,1,100000");

  a_temp_overrun: assert property (@(posedge sys_clk) disable iff (!reset_n)
    temp_sample.valid && temp_avail_live |=> temp_ovr_live && temp_avail_live)
    else $error("temperature overrun missed");

  a_press_overrun: assert property (@(posedge sys_clk) disable iff (!reset_n)
    press_sample.valid && press_avail_live |=> press_ovr_live && press_avail_live)
    else $error("pressure overrun missed");

  a_temp_avail: assert property (@(posedge sys_clk) disable iff (!reset_n)
    temp_sample.valid |=> temp_avail_live)
    else $error("temperature available not reported");

  a_press_avail: assert property (@(posedge sys_clk) disable iff (!reset_n)
    press_sample.valid |=> press_avail_live)
    else $error("pressure available not reported");

  a_flags_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !odr_tick |=> $stable(flags_snap))
    else $error("status changed between data periods");

  a_offset_sub: assert property (@(posedge sys_clk) disable iff (!reset_n)
    press_sample.valid && modes_off |=>
      pressure_result == 24'($past(press_sample.value) - {$past(offset_correction), 8'h00}))
    else $error("pressure not corrected by scaled offset");

  a_press_bytes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rd_press_high |=> rd_valid && rd_data == $past(pressure_result[23:16]))
    else $error("pressure high byte wrong");

  a_filter_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_read |=> filter_reset ##1 (filter_reset == $past(reg_req.rd && reg_req.addr == PSO_ADDR_FILTER_RES
      && modes.pressure_lowpass_filter)))
    else $error("filter reset pulse missing");

  a_flags_unused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_flags_read |=> (rd_data & 8'hCC) == 8'h00)
    else $error("unassigned status bits not zero");

endmodule

`default_nettype wire

// ---- verif/pso_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// host controller: byte reads and writes on the register port
// ************************************************************
module pso_host_model
  import pso_pkg::*;
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rd_valid,  // read answer strobe
  input  wire logic [7:0] rd_data,   // read answer byte
  output var  pso_reg_req_t reg_req  // request toward the device
);

  // idle port at time zero
  initial begin
    reg_req = '0;
  end

  // one read: strobe for one edge, then wait a bounded time for the answer
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    reg_req.rd   = 1'b1;
    reg_req.addr = addr;
    @(posedge sys_clk);
    #1;
    reg_req.rd   = 1'b0;
    reg_req.addr = ~addr;  // released lines do not keep the last value
    ok           = 1'b0;
    data         = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        ok   = 1'b1;
        data = rd_data;
      end else begin
        @(posedge sys_clk);
        #1;
      end
    end
    @(posedge sys_clk);
    #1;
  endtask

  // one write: strobe with address and byte for one edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    reg_req.wr    = 1'b1;
    reg_req.addr  = addr;
    reg_req.wdata = data;
    @(posedge sys_clk);
    #1;
    reg_req.wr    = 1'b0;
    reg_req.addr  = ~addr;
    reg_req.wdata = ~data;
    @(posedge sys_clk);
    #1;
  endtask

endmodule
`default_nettype wire

// ---- verif/pressure_sensor_output_status_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// bench for the sensor output status block
// ************************************************************
module pressure_sensor_output_status_tb
  import pso_pkg::*;
;
  logic              sys_clk;        // 125 MHz clock
  logic              reset_n;        // synchronous reset, low active
  pso_reg_req_t      reg_req;        // from host model
  pso_press_sample_t press_sample;   // pressure conversions
  pso_temp_sample_t  temp_sample;    // temperature conversions
  logic              odr_tick;       // data period pulse
  pso_modes_t        modes;          // mode levels
  logic [7:0]        rd_data;        // read byte
  logic              rd_valid;       // read answer strobe
  logic              filter_reset;   // filter reset pulse
  int                fails;          // mismatches
  int                samples_checked; // comparisons
  int                resets_seen;    // filter reset pulses counted
  int                base;           // pulse count before a read
  logic [7:0]        junk;           // unchecked read byte
  logic              ok;             // read answered
  logic [23:0]       p_exp;          // expected corrected pressure

  pso_status_core u_pso_status_core (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .press_sample(press_sample),
    .temp_sample(temp_sample), .odr_tick(odr_tick), .modes(modes), .rd_data(rd_data),
    .rd_valid(rd_valid), .filter_reset(filter_reset));

  pso_host_model u_pso_host_model (
    .sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data), .reg_req(reg_req));

  // ************************************************************
  // clock, pulse monitor, watchdog
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // count every cycle the filter reset is high, sampled mid-cycle where it is settled
  always @(negedge sys_clk) begin
    if (filter_reset === 1'b1) begin
      resets_seen++;
    end
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done();
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  // read a register and compare it
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       got;
    u_pso_host_model.read_reg(addr, d, got);
    if (!got) begin
      fails++;
      test_done();
    end
    check($sformatf("register %h", addr), d, exp);
  endtask

  // n back-to-back pressure results of the same raw value
  task automatic push_p(input logic [23:0] raw, input int n);
    press_sample.valid = 1'b1;
    press_sample.value = raw;
    repeat (n) @(posedge sys_clk);
    #1;
    press_sample.valid = 1'b0;
    press_sample.value = ~raw;
    @(posedge sys_clk);
    #1;
  endtask

  // one temperature result
  task automatic push_t(input logic [15:0] raw);
    temp_sample.valid = 1'b1;
    temp_sample.value = raw;
    @(posedge sys_clk);
    #1;
    temp_sample.valid = 1'b0;
    temp_sample.value = ~raw;
    @(posedge sys_clk);
    #1;
  endtask

  // one data period pulse
  task automatic tick();
    odr_tick = 1'b1;
    @(posedge sys_clk);
    #1;
    odr_tick = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset_n = 1'b0;
    press_sample = '0;
    temp_sample = '0;
    odr_tick = 1'b0;
    modes = '0;
    fails = 0;
    samples_checked = 0;
    resets_seen = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    // empty queue, watermark zero
    rd(8'h26, 8'h80);
    rd(8'h27, 8'h00);
    rd(8'h40, 8'h00);
    u_pso_host_model.write_reg(8'h26, 8'hFF);
    rd(8'h26, 8'h80);
    // watermark three: below, then at the level
    u_pso_host_model.write_reg(8'h14, 8'h03);
    rd(8'h14, 8'h03);
    push_p(24'h345678, 2);
    rd(8'h26, 8'h02);
    push_p(24'h345678, 1);
    rd(8'h26, 8'h83);
    // snapshot shows pressure flags after a tick, temperature flags only after the next tick
    tick();
    rd(8'h27, 8'h11);
    push_t(16'h8123);
    push_t(16'h8123);
    rd(8'h27, 8'h11);
    tick();
    rd(8'h27, 8'h33);
    rd(8'h2B, 8'h23);
    rd(8'h2C, 8'h81);
    rd(8'h28, 8'h78);
    rd(8'h29, 8'h56);
    rd(8'h2A, 8'h34);
    tick();
    rd(8'h27, 8'h00);
    rd(8'h26, 8'h02);
    // fill to the top, then overwrite
    push_p(24'h345678, 30);
    rd(8'h26, 8'hA0);
    push_p(24'h345678, 1);
    rd(8'h26, 8'hE0);
    rd(8'h2A, 8'h34);
    rd(8'h26, 8'h9F);
    // offset subtracted after scaling, with wrap
    u_pso_host_model.write_reg(8'h18, 8'h34);
    u_pso_host_model.write_reg(8'h19, 8'h12);
    rd(8'h18, 8'h34);
    p_exp = 24'h000010 - {16'h1234, 8'h00};
    push_p(24'h000010, 1);
    rd(8'h28, p_exp[7:0]);
    rd(8'h29, p_exp[15:8]);
    rd(8'h2A, p_exp[23:16]);
    // each bypass mode passes the raw value
    for (int i = 0; i < 3; i++) begin
      modes = pso_modes_t'(4'b1000 >> i);
      push_p(24'h000010, 1);
      rd(8'h28, 8'h10);
      rd(8'h2A, 8'h00);
    end
    // filter reset only while the filter is active
    modes = pso_modes_t'(4'b0001);
    base = resets_seen;
    u_pso_host_model.read_reg(8'h33, junk, ok);
    check("filter resets on", 8'(resets_seen - base), 8'h01);
    modes = '0;
    base = resets_seen;
    u_pso_host_model.read_reg(8'h33, junk, ok);
    check("filter resets off", 8'(resets_seen - base), 8'h00);
    test_done();
  end

endmodule
`default_nettype wire
